/* charger_option_pkg.sv */
// Purpose: Constants and types for the charger option control block.
// Assumes: SMBus word protocols; one option register at its command code.
// Notes:   Bit positions index the 16-bit option word.
package charger_option_pkg;
   localparam logic [7:0]  CMD_OPTION   = 8'h12;
   localparam logic [15:0] OPTION_RESET = 16'hF902;
   localparam int BIT_DEPL_LO  = 11;
   localparam int BIT_DEPL_HI  = 12;
   localparam int BIT_FREQ_UP  = 10;
   localparam int BIT_FREQ_EN  = 9;
   localparam int BIT_HS_SHORT = 8;
   localparam int BIT_LS_SHORT = 7;
   localparam int BIT_LEARN    = 6;
   localparam int BIT_MONITOR  = 5;
   localparam int BIT_ADAPTER  = 4;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [3:0] END_BIT = 4'h9;

   typedef enum logic [2:0] {
      P_IDLE = 3'b000,
      P_ADDR = 3'b001,
      P_CMD  = 3'b010,
      P_WLO  = 3'b011,
      P_WHI  = 3'b100,
      P_RLO  = 3'b101,
      P_RHI  = 3'b110,
      P_IGN  = 3'b111
   } phase_t;

   typedef struct packed {
      logic [15:0] opt;
      logic        depleted;
      logic        adapterSeen;
      logic        sclPrev;
      logic        sdaPrev;
      phase_t      phase;
      phase_t      nextPh;
      logic [3:0]  cnt;
      logic [7:0]  shift;
      logic [7:0]  cmd;
      logic [7:0]  lo;
      logic [15:0] rd;
      logic        sdaOe;
      logic        adapterSw;
      logic        batterySw;
   } state_t;

   localparam state_t STATE_RESET = '{opt: OPTION_RESET, depleted: 1'b0,
      adapterSeen: 1'b0, sclPrev: 1'b1, sdaPrev: 1'b1, phase: P_IDLE,
      nextPh: P_IDLE, cnt: 4'h0, shift: 8'h00, cmd: 8'h00, lo: 8'h00,
      rd: 16'h0000, sdaOe: 1'b0, adapterSw: 1'b1, batterySw: 1'b0};
endpackage

/* charger_option_control.sv */
// Purpose: Option register of a battery charger behind an SMBus slave.
// Assumes: SMBus pins and comparator results are synchronous to sys_clk.
// Notes:   Bits 15:13 and 3:0 are stored and read back only.
// What this block does
// - Depletion select bits 12:11, reset 11.
// - Depleted during learn: battery off, adapter on.
// - Depletion clears above rising hysteresis or at zero charge voltage.
// - Zero charge voltage disables depletion protection.
// - Bit 10 picks frequency shift down/up.
// - Bit 9 enables frequency shift, reset off.
// - Bit 8 enables high-side short detect.
// - Bit 7 picks low-side short threshold.
// - Writing learn 1 starts battery discharge.
// - Depletion ends learn, clearing bit automatically.
// - Bit 5 picks current monitor source.
// - Bit 4 reads adapter detect state.
// - Word write/read at option command code.
`timescale 1ns/1ps
module charger_option_control #(
   parameter logic [6:0] SLAVE_ADDR = 7'h0A
) (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   // SMBus pins
   input  wire logic       smbClk,
   input  wire logic       smbDataIn,
   output logic            smbDataOut,
   output logic            smbDataOe,
   // Analog status
   input  wire logic       battBelowFall,
   input  wire logic       battAboveRise,
   input  wire logic       chargeVoltageZero,
   input  wire logic       adapterDetectAbove,
   // Analog controls
   output logic [1:0]      depletionSel,
   output logic            freqShiftUp,
   output logic            freqShiftEn,
   output logic            highSideShortEn,
   output logic            lowSideThreshHigh,
   output logic            monitorSelCharge,
   output logic            adapterSwitchOn,
   output logic            batterySwitchOn
);
   import charger_option_pkg::*;

   state_t      q;
   state_t      d;
   logic        rise;
   logic        fall;
   logic        start;
   logic        stop;
   logic        isTx;
   logic        wrCommit;
   logic        rdCapture;
   logic [15:0] liveOpt;
   logic [7:0]  txByte;

   always_comb begin
      d = q;
      wrCommit = 1'b0;
      rdCapture = 1'b0;
      rise = smbClk & ~q.sclPrev;
      fall = ~smbClk & q.sclPrev;
      start = smbClk & q.sclPrev & q.sdaPrev & ~smbDataIn;
      stop = smbClk & q.sclPrev & ~q.sdaPrev & smbDataIn;
      isTx = (q.phase == P_RLO) || (q.phase == P_RHI);
      d.sclPrev = smbClk;
      d.sdaPrev = smbDataIn;
      d.adapterSeen = adapterDetectAbove;
      liveOpt = q.opt;
      liveOpt[BIT_ADAPTER] = q.adapterSeen;

      if (chargeVoltageZero) begin
         d.depleted = 1'b0;
      end else if (battBelowFall) begin
         d.depleted = 1'b1;
      end else if (battAboveRise) begin
         d.depleted = 1'b0;
      end
      if (q.opt[BIT_LEARN] && q.depleted) begin
         d.opt[BIT_LEARN] = 1'b0;
      end

      // Start and stop are checked first so a repeated start aborts any byte.
      if (start) begin
         d.phase = P_ADDR;
         d.cnt = 4'h0;
         d.sdaOe = 1'b0;
      end else if (stop) begin
         d.phase = P_IDLE;
         d.sdaOe = 1'b0;
      end else if (q.phase != P_IDLE && rise) begin
         if (q.cnt < ACK_BIT) begin
            d.shift = {q.shift[6:0], smbDataIn};
         end else if (isTx) begin
            d.nextPh = (smbDataIn || q.phase == P_RHI) ? P_IGN : P_RHI;
         end
         d.cnt = q.cnt + 4'h1;
      end else if (q.phase != P_IDLE && fall) begin
         d.sdaOe = 1'b0;
         if (q.cnt == ACK_BIT && !isTx) begin
            unique case (q.phase)
               P_ADDR: begin
                  if (q.shift[7:1] == SLAVE_ADDR) begin
                     d.sdaOe = 1'b1;
                     d.nextPh = q.shift[0] ? P_RLO : P_CMD;
                     rdCapture = q.shift[0];
                     d.rd = (q.cmd == CMD_OPTION) ? liveOpt : 16'h0000;
                  end else begin
                     d.nextPh = P_IGN;
                  end
               end
               P_CMD: begin
                  d.cmd = q.shift;
                  d.sdaOe = 1'b1;
                  d.nextPh = P_WLO;
               end
               P_WLO: begin
                  d.lo = q.shift;
                  d.sdaOe = 1'b1;
                  d.nextPh = P_WHI;
               end
               P_WHI: begin
                  d.sdaOe = 1'b1;
                  d.nextPh = P_IGN;
                  if (q.cmd == CMD_OPTION) begin
                     wrCommit = 1'b1;
                     d.opt = {q.shift, q.lo};
                     d.opt[BIT_ADAPTER] = 1'b0;
                  end
               end
               P_IDLE, P_RLO, P_RHI, P_IGN: begin
               end
            endcase
         end else if (q.cnt == END_BIT) begin
            d.cnt = 4'h0;
            d.phase = q.nextPh;
         end
         // Open drain: the line is pulled low for a zero bit only.
         txByte = (d.phase == P_RLO) ? q.rd[7:0] : q.rd[15:8];
         if ((d.phase == P_RLO || d.phase == P_RHI) && d.cnt < ACK_BIT) begin
            d.sdaOe = ~txByte[3'h7 - d.cnt[2:0]];
         end
      end
      txByte = (q.phase == P_RLO) ? q.rd[7:0] : q.rd[15:8];

      d.batterySw = d.opt[BIT_LEARN];
      d.adapterSw = ~d.opt[BIT_LEARN];
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         q <= STATE_RESET;
      end else begin
         q <= d;
      end
   end

   // The pin only ever pulls low, so the enable alone carries the data.
   assign smbDataOut        = 1'b0;
   assign smbDataOe         = q.sdaOe;
   assign depletionSel      = q.opt[BIT_DEPL_HI:BIT_DEPL_LO];
   assign freqShiftUp       = q.opt[BIT_FREQ_UP];
   assign freqShiftEn       = q.opt[BIT_FREQ_EN];
   assign highSideShortEn   = q.opt[BIT_HS_SHORT];
   assign lowSideThreshHigh = q.opt[BIT_LS_SHORT];
   assign monitorSelCharge  = q.opt[BIT_MONITOR];
   assign adapterSwitchOn   = q.adapterSw;
   assign batterySwitchOn   = q.batterySw;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   a_depl_reset: assert property ($past(sys_rst) |-> depletionSel == 2'b11
      && highSideShortEn && !lowSideThreshHigh && !monitorSelCharge)
      else $error("option fields wrong after reset");
   a_learn_stop: assert property (batterySwitchOn && q.depleted
      && !chargeVoltageZero && !wrCommit |=> adapterSwitchOn && !batterySwitchOn)
      else $error("depletion did not return to adapter");
   a_hyst_hold: assert property (q.depleted && !battAboveRise
      && !chargeVoltageZero |=> q.depleted)
      else $error("depletion released without hysteresis");
   a_zero_disable: assert property (chargeVoltageZero |=> !q.depleted)
      else $error("depletion active with zero target");
   a_freq_dir: assert property (wrCommit |=> freqShiftUp == $past(q.shift[2]))
      else $error("frequency direction not written");
   a_freq_en: assert property (wrCommit |=> freqShiftEn == $past(q.shift[1]))
      else $error("frequency enable not written");
   a_hs_short: assert property (wrCommit |=> highSideShortEn == $past(q.shift[0]))
      else $error("high side enable not written");
   a_ls_short: assert property (wrCommit |=> lowSideThreshHigh == $past(q.lo[7]))
      else $error("low side threshold not written");
   a_learn_start: assert property (wrCommit && q.lo[6]
      |=> batterySwitchOn && !adapterSwitchOn)
      else $error("learn write did not start discharge");
   a_learn_clear: assert property (q.opt[BIT_LEARN] && q.depleted
      && !wrCommit |=> !q.opt[BIT_LEARN])
      else $error("learn bit not cleared on depletion");
   a_mon_sel: assert property (wrCommit |=> monitorSelCharge == $past(q.lo[5]))
      else $error("monitor select not written");
   a_adapter_rd: assert property (rdCapture && q.cmd == CMD_OPTION
      |=> q.rd[BIT_ADAPTER] == $past(q.adapterSeen))
      else $error("adapter indication not read live");
   a_adapter_ro: assert property (wrCommit |=> !q.opt[BIT_ADAPTER])
      else $error("adapter bit took a write");
   a_word_read: assert property (rdCapture && q.cmd == CMD_OPTION
      |=> q.rd[15:5] == $past(q.opt[15:5]))
      else $error("read word not the option value");

   // Power path: exactly one switch conducts at any time, so the system rail never floats.
   a_switch_excl: assert property (adapterSwitchOn != batterySwitchOn)
      else $error("power switches not complementary");
   a_depl_set: assert property (battBelowFall && !chargeVoltageZero |=> q.depleted)
      else $error("depletion not flagged below threshold");
   a_depl_release: assert property (!battBelowFall && battAboveRise
      && !chargeVoltageZero |=> !q.depleted)
      else $error("depletion held above hysteresis");
   a_depl_sel_wr: assert property (wrCommit |=> depletionSel == $past(q.shift[4:3]))
      else $error("depletion select not written");

   // Learn cycle: only a host write or a depletion may change the learn state.
   a_learn_keep: assert property (q.opt[BIT_LEARN] && !q.depleted && !wrCommit
      |=> q.opt[BIT_LEARN])
      else $error("learn ended without depletion");
   a_learn_off: assert property (!q.opt[BIT_LEARN] && !wrCommit
      |=> adapterSwitchOn && !batterySwitchOn)
      else $error("discharge started without a write");
   a_learn_wr0: assert property (wrCommit && !q.lo[6]
      |=> adapterSwitchOn && !batterySwitchOn)
      else $error("learn write of zero left battery on");
   a_zero_keep: assert property (chargeVoltageZero && q.opt[BIT_LEARN] && !q.depleted
      && !wrCommit |=> batterySwitchOn)
      else $error("learn stopped with protection disabled");
   a_learn_track: assert property (batterySwitchOn == q.opt[BIT_LEARN])
      else $error("battery switch not following learn bit");

   // Register fields other than learn move only on a committed word write to the option command.
   a_fields_hold: assert property (!wrCommit |=> $stable(depletionSel)
      && $stable(freqShiftUp) && $stable(freqShiftEn) && $stable(highSideShortEn)
      && $stable(lowSideThreshHigh) && $stable(monitorSelCharge))
      else $error("option field moved without a write");
   a_other_write: assert property (fall && q.phase == P_WHI && q.cnt == ACK_BIT
      && q.cmd != CMD_OPTION |=> $stable(depletionSel) && $stable(monitorSelCharge))
      else $error("other command write reached the options");
   a_adapter_stored: assert property (!q.opt[BIT_ADAPTER])
      else $error("adapter bit stored a one");
   a_read_other: assert property (rdCapture && q.cmd != CMD_OPTION
      |=> q.rd == 16'h0000)
      else $error("other command read not zero");

   // Bus framing: the enable changes while the host holds the clock low, except that a start or a stop releases it.
   // These rely on each clock phase lasting at least two system clocks.
   a_oe_rise_low: assert property ($rose(smbDataOe) |-> !smbClk)
      else $error("data pulled low while clock high");
   a_idle_quiet: assert property (q.phase == P_IDLE |-> !smbDataOe)
      else $error("data driven while bus idle");
   a_start_addr: assert property (start |=> q.phase == P_ADDR && q.cnt == 4'h0)
      else $error("start did not open address phase");
   a_stop_idle: assert property (stop |=> q.phase == P_IDLE)
      else $error("stop did not return to idle");
   a_cnt_range: assert property (q.cnt <= END_BIT)
      else $error("bit counter out of range");
   a_ack_stands: assert property (smbDataOe && !fall && !start && !stop
      |=> smbDataOe)
      else $error("driven bit dropped before clock fall");
   a_addr_ack: assert property (fall && q.phase == P_ADDR && q.cnt == ACK_BIT
      && q.shift[7:1] == SLAVE_ADDR |=> smbDataOe)
      else $error("own address not acknowledged");
   a_addr_nak: assert property (fall && q.phase == P_ADDR && q.cnt == ACK_BIT
      && q.shift[7:1] != SLAVE_ADDR |=> !smbDataOe)
      else $error("foreign address acknowledged");
   a_data_ack: assert property (fall && q.cnt == ACK_BIT && (q.phase == P_CMD
      || q.phase == P_WLO || q.phase == P_WHI) |=> smbDataOe)
      else $error("written byte not acknowledged");
   a_tx_release: assert property (fall && isTx && q.cnt == ACK_BIT |=> !smbDataOe)
      else $error("data not released for host acknowledge");
   a_tx_first: assert property (fall && q.phase == P_ADDR && q.cnt == END_BIT
      && q.nextPh == P_RLO |=> smbDataOe == !$past(q.rd[7]))
      else $error("first read bit wrong");
   a_tx_high: assert property (fall && q.phase == P_RLO && q.cnt == END_BIT
      && q.nextPh == P_RHI |=> smbDataOe == !$past(q.rd[15]))
      else $error("first high byte bit wrong");
   a_ack_end: assert property (fall && q.cnt == END_BIT && q.nextPh != P_RLO
      && q.nextPh != P_RHI |=> !smbDataOe)
      else $error("acknowledge not released");
endmodule

/* smb_host.sv */
// Purpose: Behavioural SMBus host issuing word writes and word reads.
// Assumes: The data line is pulled up; the device pulls it low via smbDataOe.
// Notes:   SCL stays low for two sys_clk cycles and high for four; two is the minimum the device takes.
`timescale 1ns/1ps
module smb_host #(
   parameter logic [6:0] SLAVE_ADDR = 7'h0A
) (
   // Clock
   input  wire logic sys_clk,
   // Bus
   input  wire logic smbDataOe,
   output logic      smbClk,
   output logic      smbDataIn
);
   logic hostSda = 1'b1;
   initial smbClk = 1'b1;
   assign smbDataIn = hostSda & ~smbDataOe;
   task automatic hold(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic edges(input logic s0, input logic s1);
      hostSda = s0;
      hold(2);
      smbClk = 1'b1;
      hold(2);
      hostSda = s1;
      hold(2);
   endtask
   task automatic bitx(input logic b, output logic r);
      hostSda = b;
      hold(2);
      smbClk = 1'b1;
      hold(2);
      r = smbDataIn;
      hold(2);
      smbClk = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
                       output logic ao);
      for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
      bitx(ai, ao);
   endtask
   task automatic start;
      edges(1'b1, 1'b0);
      smbClk = 1'b0;
   endtask
   task automatic writeWord(input logic [7:0] cmd, input logic [15:0] w, output logic nak);
      logic [7:0] rx;
      logic [3:0] a;
      start();
      xfer({SLAVE_ADDR, 1'b0}, 1'b1, rx, a[0]);
      xfer(cmd, 1'b1, rx, a[1]);
      xfer(w[7:0], 1'b1, rx, a[2]);
      xfer(w[15:8], 1'b1, rx, a[3]);
      edges(1'b0, 1'b1);
      nak = |a;
   endtask
   task automatic readWord(input logic [7:0] cmd, output logic [15:0] w, output logic nak);
      logic [7:0] rx;
      logic [2:0] a;
      logic       n;
      start();
      xfer({SLAVE_ADDR, 1'b0}, 1'b1, rx, a[0]);
      xfer(cmd, 1'b1, rx, a[1]);
      start();
      xfer({SLAVE_ADDR, 1'b1}, 1'b1, rx, a[2]);
      xfer(8'hFF, 1'b0, w[7:0], n);
      xfer(8'hFF, 1'b1, w[15:8], n);
      edges(1'b0, 1'b1);
      nak = |a;
   endtask
endmodule

/* charger_option_control_tb_top.sv */
// Purpose: Self-checking bench for the charger option control block.
// Assumes: The host model drives SMBus; comparator levels come from here.
// Notes:   Inputs change on the falling edge of sys_clk.
`timescale 1ns/1ps
module charger_option_control_tb_top;
   import charger_option_pkg::*;
   logic        sys_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        smbClk, smbDataIn, smbDataOut, smbDataOe, nak;
   logic        battBelowFall = 1'b0, battAboveRise = 1'b1;
   logic        chargeVoltageZero = 1'b0, adapterDetectAbove = 1'b0;
   logic        freqShiftUp, freqShiftEn, highSideShortEn, lowSideThreshHigh;
   logic        monitorSelCharge, adapterSwitchOn, batterySwitchOn;
   logic [1:0]  depletionSel;
   logic [15:0] rdWord;
   int          bad_count = 0;
   int          samples_checked = 0;
   always #50 sys_clk = ~sys_clk;
   charger_option_control u_charger_option_control (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .smbClk(smbClk), .smbDataIn(smbDataIn), .smbDataOut(smbDataOut),
      .smbDataOe(smbDataOe), .battBelowFall(battBelowFall), .battAboveRise(battAboveRise),
      .chargeVoltageZero(chargeVoltageZero), .adapterDetectAbove(adapterDetectAbove),
      .depletionSel(depletionSel), .freqShiftUp(freqShiftUp), .freqShiftEn(freqShiftEn),
      .highSideShortEn(highSideShortEn), .lowSideThreshHigh(lowSideThreshHigh),
      .monitorSelCharge(monitorSelCharge), .adapterSwitchOn(adapterSwitchOn),
      .batterySwitchOn(batterySwitchOn));
   smb_host u_smb_host (.sys_clk(sys_clk), .smbDataOe(smbDataOe), .smbClk(smbClk),
      .smbDataIn(smbDataIn));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic option_fields;
      logic [15:0] w;
      for (int k = 0; k < 3; k++) begin
         w = (k == 0) ? 16'hF902 : (k == 1) ? 16'h06B0 : 16'h0980;
         adapterDetectAbove = k[1];
         if (k > 0) begin
            u_smb_host.writeWord(CMD_OPTION, w, nak);
            check(nak, 1'b0);
         end
         u_smb_host.readWord(CMD_OPTION, rdWord, nak);
         check(nak, 1'b0);
         check(depletionSel, w[12:11]);
         check(freqShiftUp, w[10]);
         check(freqShiftEn, w[9]);
         check(highSideShortEn, w[8]);
         check(lowSideThreshHigh, w[7]);
         check(monitorSelCharge, w[5]);
         check(rdWord[4], k[1]);
         check(rdWord, {w[15:5], k[1], w[3:0]});
      end
      u_smb_host.writeWord(8'h14, 16'hFFFF, nak);
      check(nak, 1'b0);
      check(smbDataOut, 1'b0);
      u_smb_host.readWord(CMD_OPTION, rdWord, nak);
      check(rdWord, 16'h0990);
   endtask
   task automatic learn_cycle;
      check({adapterSwitchOn, batterySwitchOn}, 2'b10);
      u_smb_host.writeWord(CMD_OPTION, 16'h0840, nak);
      check({adapterSwitchOn, batterySwitchOn}, 2'b01);
      u_smb_host.writeWord(CMD_OPTION, 16'h0800, nak);
      check({adapterSwitchOn, batterySwitchOn}, 2'b10);
      u_smb_host.writeWord(CMD_OPTION, 16'h0840, nak);
      battBelowFall = 1'b1;
      battAboveRise = 1'b0;
      u_smb_host.hold(4);
      check({adapterSwitchOn, batterySwitchOn}, 2'b10);
      u_smb_host.readWord(CMD_OPTION, rdWord, nak);
      check(rdWord[6], 1'b0);
      // Inside the hysteresis band the battery still counts as depleted.
      battBelowFall = 1'b0;
      u_smb_host.writeWord(CMD_OPTION, 16'h0840, nak);
      check(batterySwitchOn, 1'b0);
      battAboveRise = 1'b1;
      u_smb_host.hold(4);
      u_smb_host.writeWord(CMD_OPTION, 16'h0840, nak);
      check(batterySwitchOn, 1'b1);
      chargeVoltageZero = 1'b1;
      battBelowFall = 1'b1;
      battAboveRise = 1'b0;
      u_smb_host.hold(4);
      check(batterySwitchOn, 1'b1);
   endtask
   initial begin
      repeat (2) @(negedge sys_clk);
      sys_rst = 1'b0;
      repeat (2) @(negedge sys_clk);
      option_fields();
      learn_cycle();
      results();
   end
   initial begin
      repeat (50000) @(posedge sys_clk);
      bad_count++;
      results();
   end
endmodule
